// [dic_pkg.sv]
// Shared constants, types and helpers of the dispatch, issue and
// completion control. Assumes one core clock and an upstream rename-map
// lookup that tells each source operand whether it lives in a rename.
package dic_pkg;
  localparam int SLOTS         = 3;   // Dispatch and retire width
  localparam int WB_MAX        = 3;   // Rename write-backs per file per cycle
  localparam int CF_DEPTH      = 16;  // Completion fifo entries
  localparam int CF_W          = 4;
  localparam int UNITS         = 5;
  localparam int FILES         = 6;
  localparam int BIG_FILES     = 3;   // General, float, vector
  localparam int RN_W          = 4;
  localparam logic [4:0] RN_BIG   = 5'h10;
  localparam logic [4:0] RN_SMALL = 5'h01;
  localparam int RS_WIDE_UNITS = 3;   // Load/store, complex int, float
  localparam int RS_WIDE       = 2;
  localparam int RS_NARROW     = 1;

  typedef enum logic [2:0] {
    U_LOAD_STORE  = 3'b000,
    U_COMPLEX_INT = 3'b001,
    U_FLOAT       = 3'b010,
    U_SIMPLE_INT  = 3'b011,
    U_VECTOR      = 3'b100,
    U_NONE        = 3'b111   // Branch: completion entry only
  } unit_e;

  typedef enum logic [1:0] {
    SER_NONE    = 2'b00,
    SER_EXEC    = 2'b01,
    SER_REFETCH = 2'b10,
    SER_STORE   = 2'b11
  } ser_e;

  // File index: 0 general, 1 float, 2 vector, 3 condition, 4 link, 5 count
  typedef struct packed {
    logic            need;
    logic            renamed;
    logic [2:0]      file;
    logic [RN_W-1:0] tag;
  } src_s;

  typedef struct packed {
    logic                  valid;
    unit_e                 unit;
    ser_e                  ser;
    logic                  branch_pred;
    logic [FILES-1:0][1:0] dst;
    src_s [1:0]            src;
  } instr_s;

  typedef struct packed {
    logic            need;
    logic            pend;
    logic            from_rename;
    logic [2:0]      file;
    logic [RN_W-1:0] tag;
  } opnd_s;

  typedef struct packed {
    logic            valid;
    logic            exec_ser;
    logic [CF_W-1:0] cf_idx;
    logic [2:0]      dst_file;
    logic [RN_W-1:0] dst_tag;
    opnd_s [1:0]     opnd;
  } rs_ent_s;

  typedef struct packed {
    logic                  valid;
    logic                  finished;
    logic                  exc;
    logic                  unresolved;
    ser_e                  ser;
    logic [FILES-1:0][1:0] dst;
  } cf_ent_s;

  typedef struct packed {
    logic            valid;
    logic            exc;
    logic            has_res;
    logic [CF_W-1:0] cf_idx;
    logic [2:0]      file;
    logic [RN_W-1:0] tag;
  } fin_s;

  typedef struct packed {
    logic [1:0]      cnt;
    logic [RN_W-1:0] tag;
  } wb_s;

  function automatic logic [4:0] rn_size(input int f);
    return (f < BIG_FILES) ? RN_BIG : RN_SMALL;
  endfunction

  function automatic int rs_depth(input int u);
    return (u < RS_WIDE_UNITS) ? RS_WIDE : RS_NARROW;
  endfunction

  // Rename pointer modulo the file's rename count
  function automatic logic [RN_W-1:0] rn_wrap(input int f,
                                              input logic [4:0] v);
    return (f < BIG_FILES) ? v[RN_W-1:0] : 4'h0;
  endfunction

  // A unit writes this rename in the current cycle
  function automatic logic fin_hit(input fin_s f [UNITS],
                                   input logic [2:0] file,
                                   input logic [RN_W-1:0] tag);
    logic hit;
    hit = 1'b0;
    for (int u = 0; u < UNITS; u++)
      if (f[u].valid && f[u].has_res && f[u].file == file &&
          f[u].tag == tag)
        hit = 1'b1;
    return hit;
  endfunction

  function automatic logic [CF_W-1:0] cf_age(input logic [CF_W-1:0] idx,
                                             input logic [CF_W-1:0] head);
    return idx - head;
  endfunction
endpackage

// [rs_station.sv]
// Reservation station of one execution unit, one or two entries deep.
// Assumes entries arrive in program order and flushes come as a kill mask.
`timescale 1ns/10ps
module rs_station #(
  parameter int DEPTH = 1
) (
  input  logic                         clk,
  input  logic                         reset_n,
  input  logic                         load,
  input  dic_pkg::rs_ent_s             load_ent,
  input  dic_pkg::fin_s                fin [dic_pkg::UNITS],
  input  logic [dic_pkg::CF_DEPTH-1:0] kill_vec,
  input  logic [dic_pkg::CF_W-1:0]     oldest_idx,
  output logic                         accept,
  output logic                         start,
  output dic_pkg::rs_ent_s             issue_ent
);
  import dic_pkg::*;

  rs_ent_s ent_q [DEPTH];
  rs_ent_s ent_d [DEPTH];
  logic    held_ser;
  logic    ops_rdy;

  // An execution-serialized entry closes the station to new work
  always_comb begin
    held_ser = 1'b0;
    for (int i = 0; i < DEPTH; i++)
      if (ent_q[i].valid && ent_q[i].exec_ser)
        held_ser = 1'b1;
    accept = !held_ser && !ent_q[DEPTH-1].valid;
  end

  // Bottom entry only; a result landing this cycle counts as ready
  always_comb begin
    ops_rdy = 1'b1;
    for (int s = 0; s < 2; s++)
      if (ent_q[0].opnd[s].need && ent_q[0].opnd[s].pend &&
          !fin_hit(fin, ent_q[0].opnd[s].file, ent_q[0].opnd[s].tag))
        ops_rdy = 1'b0;
  end

  assign start = ent_q[0].valid && ops_rdy &&
                 !kill_vec[ent_q[0].cf_idx] &&
                 (!ent_q[0].exec_ser ||
                  ent_q[0].cf_idx == oldest_idx);
  assign issue_ent = ent_q[0];

  // Wake-up, kill, compaction toward the bottom, then load
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      ent_d[i] = ent_q[i];
      for (int s = 0; s < 2; s++)
        if (fin_hit(fin, ent_q[i].opnd[s].file, ent_q[i].opnd[s].tag))
          ent_d[i].opnd[s].pend = 1'b0;
      if (kill_vec[ent_q[i].cf_idx])
        ent_d[i].valid = 1'b0;
    end
    if (start)
      ent_d[0].valid = 1'b0;
    if (!ent_d[0].valid) begin
      ent_d[0] = ent_d[DEPTH-1];
      ent_d[DEPTH-1].valid = 1'b0;
    end
    if (load) begin
      if (!ent_d[0].valid)
        ent_d[0] = load_ent;
      else
        ent_d[DEPTH-1] = load_ent;
    end
  end

  // Station registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++)
        ent_q[i] <= '0;
    end else begin
      ent_q <= ent_d;
    end
  end
endmodule // rs_station

// [dispatch_issue_completion_ctrl.sv]
// Dispatch from the fetch queue, issue to reservation stations, rename
// allocation and in-order retirement through the completion fifo.
// Assumes units report finish with the completion index, and the branch
// unit reports resolution; architected register copies happen outside.
`timescale 1ns/10ps
module dispatch_issue_completion_ctrl (
  input  logic                      clk,
  input  logic                      reset_n,
  input  dic_pkg::instr_s           fq_slot [dic_pkg::SLOTS],
  output logic [1:0]                fq_take,
  output logic [dic_pkg::CF_W-1:0]  disp_base,
  input  dic_pkg::fin_s             fin [dic_pkg::UNITS],
  input  logic                      br_valid,
  input  logic [dic_pkg::CF_W-1:0]  br_idx,
  input  logic                      br_mispredict,
  output logic [dic_pkg::UNITS-1:0] unit_start,
  output dic_pkg::rs_ent_s          unit_op [dic_pkg::UNITS],
  output logic [1:0]                retire_cnt,
  output dic_pkg::wb_s              wb [dic_pkg::FILES],
  output logic                      prog_int,
  output logic [dic_pkg::CF_W-1:0]  prog_int_idx,
  output logic                      refetch,
  output logic                      store_commit,
  output logic [dic_pkg::CF_W-1:0]  store_commit_idx
);
  import dic_pkg::*;

  cf_ent_s         cf_q [CF_DEPTH];
  cf_ent_s         cf_d [CF_DEPTH];
  logic [CF_W-1:0] head_q, head_d, tail_q, tail_d;
  logic [4:0]      count_q, count_d;
  logic [RN_W-1:0] rn_alloc_q [FILES];
  logic [RN_W-1:0] rn_alloc_d [FILES];
  logic [4:0]      rn_free_q [FILES];
  logic [4:0]      rn_free_d [FILES];
  logic [15:0]     rn_ready_q [FILES];
  logic [15:0]     rn_ready_d [FILES];
  wb_s             wb_d [FILES];
  logic [1:0]      retire_d;
  logic            pint_d, refetch_d, stc_d;
  logic [CF_W-1:0] pidx_d, stc_idx_d, idx;
  logic [CF_DEPTH-1:0] kill_vec;
  logic [UNITS-1:0] rs_load, rs_accept, used;
  rs_ent_s         rs_in [UNITS];
  rs_ent_s         ent;
  logic [1:0]      ndisp;
  logic            stop, flush_all, mispred, fits, ok;
  logic [2:0]      wbsum [FILES];
  logic [4:0]      flcnt [FILES];
  logic [4:0]      alsum [FILES];
  logic [4:0]      nkill;
  src_s            src;
  int              ui;

  // Completion, flush, rename and dispatch bookkeeping
  always_comb begin
    cf_d       = cf_q;
    rn_ready_d = rn_ready_q;
    kill_vec   = '0;
    rs_load    = '0;
    used       = '0;
    retire_d   = 2'h0;
    pint_d     = 1'b0;
    pidx_d     = prog_int_idx;
    refetch_d  = 1'b0;
    stc_d      = 1'b0;
    stc_idx_d  = store_commit_idx;
    stop       = 1'b0;
    flush_all  = 1'b0;
    mispred    = 1'b0;
    ndisp      = 2'h0;
    nkill      = 5'h00;
    fits       = 1'b1;
    ok         = 1'b1;
    idx        = head_q;
    ent        = '0;
    src        = '0;
    ui         = 0;
    for (int u = 0; u < UNITS; u++)
      rs_in[u] = '0;
    for (int f = 0; f < FILES; f++) begin
      wbsum[f] = 3'h0;
      flcnt[f] = 5'h00;
      alsum[f] = 5'h00;
    end

    // Retire from the oldest slot upward
    for (int k = 0; k < SLOTS; k++) begin
      idx = head_q + CF_W'(k);
      if (!stop) begin
        fits = 1'b1;
        for (int f = 0; f < FILES; f++)
          if (wbsum[f] + {1'b0, cf_q[idx].dst[f]} > WB_MAX)
            fits = 1'b0;
        if (!cf_q[idx].valid || !cf_q[idx].finished)
          stop = 1'b1;
        else if (cf_q[idx].unresolved)
          stop = 1'b1;
        else if (k != 0 && cf_q[idx].ser != SER_NONE)
          stop = 1'b1;
        else if (cf_q[idx].exc) begin
          stop = 1'b1;
          if (k == 0) begin
            pint_d    = 1'b1;
            pidx_d    = idx;
            flush_all = 1'b1;
          end
        end else if (!fits)
          stop = 1'b1;
        else begin
          cf_d[idx].valid = 1'b0;
          retire_d = retire_d + 2'h1;
          for (int f = 0; f < FILES; f++)
            wbsum[f] = wbsum[f] + {1'b0, cf_q[idx].dst[f]};
          if (cf_q[idx].ser == SER_STORE) begin
            stc_d     = 1'b1;
            stc_idx_d = idx;
          end
          if (cf_q[idx].ser == SER_EXEC || cf_q[idx].ser == SER_REFETCH)
            stop = 1'b1;
          if (cf_q[idx].ser == SER_REFETCH) begin
            refetch_d = 1'b1;
            flush_all = 1'b1;
          end
        end
      end
    end

    // Resolution is seen by retirement one cycle later
    if (br_valid && cf_q[br_idx].valid) begin
      cf_d[br_idx].unresolved = 1'b0;
      mispred = br_mispredict && !flush_all;
    end

    // Finish reports and rename result arrival; a dispatch clear further down wins over the set
    for (int u = 0; u < UNITS; u++)
      if (fin[u].valid) begin
        if (cf_q[fin[u].cf_idx].valid) begin
          cf_d[fin[u].cf_idx].finished = 1'b1;
          if (fin[u].exc)
            cf_d[fin[u].cf_idx].exc = 1'b1;
        end
        if (fin[u].has_res && int'(fin[u].file) < FILES)
          rn_ready_d[fin[u].file][fin[u].tag] = 1'b1;
      end

    // Flush younger entries, or every entry on a full flush; their renames go back to the free pool
    for (int i = 0; i < CF_DEPTH; i++) begin
      idx = CF_W'(i);
      if (cf_d[idx].valid && (flush_all || (mispred &&
          cf_age(idx, head_q) > cf_age(br_idx, head_q)))) begin
        kill_vec[idx]   = 1'b1;
        cf_d[idx].valid = 1'b0;
        nkill = nkill + 5'h01;
        for (int f = 0; f < FILES; f++)
          flcnt[f] = flcnt[f] + {3'h0, cf_q[idx].dst[f]};
      end
    end

    // Dispatch in order; no dispatch while a flush is in progress
    stop = flush_all || mispred;
    for (int i = 0; i < SLOTS; i++) begin
      if (!stop) begin
        ok = fq_slot[i].valid;
        ui = int'(fq_slot[i].unit);
        if (count_q + {3'h0, ndisp} >= 5'(CF_DEPTH))
          ok = 1'b0;
        for (int f = 0; f < FILES; f++)
          if (alsum[f] + {3'h0, fq_slot[i].dst[f]} > rn_free_q[f])
            ok = 1'b0;
        if (fq_slot[i].unit != U_NONE &&
            (ui >= UNITS || used[ui] || !rs_accept[ui]))
          ok = 1'b0;
        if (i != 0 && fq_slot[i].ser != SER_NONE)
          ok = 1'b0;
        if (!ok)
          stop = 1'b1;
        else begin
          idx = tail_q + CF_W'(ndisp);
          cf_d[idx].valid      = 1'b1;
          cf_d[idx].finished   = (fq_slot[i].unit == U_NONE);
          cf_d[idx].exc        = 1'b0;
          cf_d[idx].unresolved = fq_slot[i].branch_pred;
          cf_d[idx].ser        = fq_slot[i].ser;
          cf_d[idx].dst        = fq_slot[i].dst;
          ent          = '0;
          ent.valid    = 1'b1;
          ent.exec_ser = (fq_slot[i].ser == SER_EXEC);
          ent.cf_idx   = idx;
          // Lowest file with a result names the first destination tag
          for (int f = FILES - 1; f >= 0; f--)
            if (fq_slot[i].dst[f] != 2'h0) begin
              ent.dst_file = 3'(f);
              ent.dst_tag  = rn_wrap(f, {1'b0, rn_alloc_q[f]} + alsum[f]);
            end
          for (int f = 0; f < FILES; f++) begin
            for (int j = 0; j < 2; j++)
              if (j < int'(fq_slot[i].dst[f]))
                rn_ready_d[f][rn_wrap(f, {1'b0, rn_alloc_q[f]} + alsum[f] +
                                         5'(j))] = 1'b0;
            alsum[f] = alsum[f] + {3'h0, fq_slot[i].dst[f]};
          end
          // Next value, so a tag allocated by a lower slot this cycle is pending
          for (int s = 0; s < 2; s++) begin
            src = fq_slot[i].src[s];
            ent.opnd[s].need        = src.need;
            ent.opnd[s].from_rename = src.renamed;
            ent.opnd[s].file        = src.file;
            ent.opnd[s].tag         = src.tag;
            ent.opnd[s].pend        = src.need && src.renamed &&
                                      int'(src.file) < FILES &&
                                      !rn_ready_d[src.file][src.tag] &&
                                      !fin_hit(fin, src.file, src.tag);
          end
          if (fq_slot[i].unit != U_NONE) begin
            rs_load[ui] = 1'b1;
            rs_in[ui]   = ent;
            used[ui]    = 1'b1;
          end
          ndisp = ndisp + 2'h1;
          if (fq_slot[i].ser != SER_NONE)
            stop = 1'b1;
        end
      end
    end

    // Rename pools and write-back report
    for (int f = 0; f < FILES; f++) begin
      rn_free_d[f]  = rn_free_q[f] + {2'h0, wbsum[f]} + flcnt[f] -
                      alsum[f];
      rn_alloc_d[f] = rn_wrap(f, {1'b0, rn_alloc_q[f]} + alsum[f] -
                                 flcnt[f]);
      wb_d[f].cnt   = wbsum[f][1:0];
      wb_d[f].tag   = rn_wrap(f, {1'b0, rn_alloc_q[f]} + rn_free_q[f] -
                                 rn_size(f));
    end
    head_d  = head_q + CF_W'(retire_d);
    count_d = count_q - {3'h0, retire_d} - nkill + {3'h0, ndisp};
    if (flush_all)
      tail_d = head_d;
    else if (mispred)
      tail_d = br_idx + 4'h1;
    else
      tail_d = tail_q + CF_W'(ndisp);
  end

  assign fq_take   = ndisp;
  assign disp_base = tail_q;

  // One station per unit; depth set by unit class
  for (genvar u = 0; u < UNITS; u++) begin : g_rs
    rs_station #(
      .DEPTH(rs_depth(u))
    ) u_rs (
      .clk        (clk),
      .reset_n    (reset_n),
      .load       (rs_load[u]),
      .load_ent   (rs_in[u]),
      .fin        (fin),
      .kill_vec   (kill_vec),
      .oldest_idx (head_q),
      .accept     (rs_accept[u]),
      .start      (unit_start[u]),
      .issue_ent  (unit_op[u])
    );
  end

  // State registers; rename pools start full
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CF_DEPTH; i++)
        cf_q[i] <= '0;
      for (int f = 0; f < FILES; f++) begin
        rn_alloc_q[f] <= 4'h0;
        rn_free_q[f]  <= rn_size(f);
        rn_ready_q[f] <= 16'h0000;
        wb[f]         <= '0;
      end
      head_q           <= 4'h0;
      tail_q           <= 4'h0;
      count_q          <= 5'h00;
      retire_cnt       <= 2'h0;
      prog_int         <= 1'b0;
      prog_int_idx     <= 4'h0;
      refetch          <= 1'b0;
      store_commit     <= 1'b0;
      store_commit_idx <= 4'h0;
    end else begin
      cf_q             <= cf_d;
      rn_alloc_q       <= rn_alloc_d;
      rn_free_q        <= rn_free_d;
      rn_ready_q       <= rn_ready_d;
      wb               <= wb_d;
      head_q           <= head_d;
      tail_q           <= tail_d;
      count_q          <= count_d;
      retire_cnt       <= retire_d;
      prog_int         <= pint_d;
      prog_int_idx     <= pidx_d;
      refetch          <= refetch_d;
      store_commit     <= stc_d;
      store_commit_idx <= stc_idx_d;
    end
  end
endmodule // dispatch_issue_completion_ctrl

// [dispatch_issue_completion_ctrl_assertions.sv]
// Checker for the dispatch and retire control, bound to its top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module dispatch_issue_completion_ctrl_assertions
  import dic_pkg::*;
(
  input logic                clk,
  input logic                reset_n,
  input instr_s              fq_slot [SLOTS],
  input logic [1:0]          fq_take,
  input logic [CF_W-1:0]     disp_base,
  input logic [UNITS-1:0]    unit_start,
  input rs_ent_s             unit_op [UNITS],
  input logic [1:0]          retire_cnt,
  input wb_s                 wb [FILES],
  input logic                prog_int,
  input logic [CF_W-1:0]     prog_int_idx,
  input logic                refetch,
  input logic                store_commit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_lead_slot:
    assert property (!fq_slot[0].valid |-> fq_take == 2'h0)
    else $error("take without oldest slot");
  a_mid_slot:
    assert property (!fq_slot[1].valid |-> fq_take < 2'h2)
    else $error("take past empty slot");
  a_three_max:
    assert property (!fq_slot[2].valid |-> fq_take != 2'h3)
    else $error("third slot taken while empty");
  a_ser_alone:
    assert property (fq_slot[1].valid && fq_slot[1].ser != SER_NONE
                     |-> fq_take < 2'h2)
    else $error("serializing taken behind another");
  a_base_step:
    assert property (fq_take != 2'h0 |=>
                     disp_base == $past(disp_base) + 4'($past(fq_take)))
    else $error("tail did not advance by take");
  a_int_none:
    assert property (prog_int |-> retire_cnt == 2'h0 ##1 !prog_int[*2])
    else $error("interrupt with retirement");
  a_int_hold:
    assert property (!prog_int |-> $stable(prog_int_idx))
    else $error("interrupt index moved");
  a_refetch_one:
    assert property (refetch |-> retire_cnt == 2'h1)
    else $error("refetch retire not single");
  a_store_ret:
    assert property (store_commit |-> retire_cnt != 2'h0)
    else $error("commit without retirement");
  a_wb_idle:
    assert property (retire_cnt == 2'h0 |-> wb[0].cnt == 2'h0
                     && wb[1].cnt == 2'h0)
    else $error("write-back without retirement");
  a_start_entry:
    assert property (unit_start[0] |-> unit_op[0].valid)
    else $error("start without entry");
endmodule // dispatch_issue_completion_ctrl_assertions

// [dic_far_model.sv]
// Far side: a fetch queue that shifts by the take count, and units that
// finish one or two cycles after start.
// Assumes the bench loads the program while the queue is empty.
`timescale 1ns/10ps
module dic_far_model
  import dic_pkg::*;
(
  input  logic             clk,
  input  logic             reset_n,
  input  instr_s           prog [16],
  input  logic [4:0]       len,
  input  logic             restart,
  input  logic             slow,
  input  logic [UNITS-1:0] exc_unit,
  input  logic [1:0]       fq_take,
  input  logic [UNITS-1:0] unit_start,
  input  rs_ent_s          unit_op [UNITS],
  output instr_s           fq_slot [SLOTS],
  output fin_s             fin [UNITS]
);
  logic [4:0] ptr_q;
  logic [4:0] ptr_d;
  fin_s       st1_q [UNITS];
  fin_s       st1_d [UNITS];
  fin_s       st2_q [UNITS];

  // Queue shifts by the take; empty slots show a junk pattern
  always_comb begin
    ptr_d = (restart || !reset_n) ? 5'h00 : ptr_q + 5'(fq_take);
    for (int i = 0; i < SLOTS; i++) begin
      fq_slot[i] = '1;
      fq_slot[i].valid = 1'b0;
      if (!restart && ptr_q + 5'(i) < len)
        fq_slot[i] = prog[4'(ptr_q + 5'(i))];
    end
  end

  // Result goes to the entry's own rename; slow adds a cycle
  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      st1_d[u] = '0;
      st1_d[u].valid = unit_start[u];
      st1_d[u].exc = exc_unit[u];
      st1_d[u].has_res = 1'b1;
      st1_d[u].cf_idx = unit_op[u].cf_idx;
      st1_d[u].file = unit_op[u].dst_file;
      st1_d[u].tag = unit_op[u].dst_tag;
      fin[u] = slow ? st2_q[u] : st1_q[u];
    end
  end

  always_ff @(posedge clk) begin
    ptr_q <= ptr_d;
    st1_q <= st1_d;
    st2_q <= st1_q;
  end
endmodule // dic_far_model

// [dispatch_issue_completion_ctrl_tb_top.sv]
// Bench: dispatch width, write-back limit, serialization, store commit,
// mispredict flush and interrupt through the far-side model.
// Assumes the checker and the model are compiled first.
`timescale 1ns/10ps
module dispatch_issue_completion_ctrl_tb_top;
  import dic_pkg::*;
  logic             clk, reset_n, restart, slow;
  logic             br_valid, br_mispredict;
  logic             prog_int, refetch, store_commit;
  logic [4:0]       len;
  logic [3:0]       br_idx, disp_base, prog_int_idx, store_commit_idx;
  logic [1:0]       fq_take, retire_cnt, t0;
  logic [UNITS-1:0] exc_unit, unit_start;
  instr_s           prog [16];
  instr_s           fq_slot [SLOTS];
  fin_s             fin [UNITS];
  rs_ent_s          unit_op [UNITS];
  wb_s              wb [FILES];
  int               errors, checks, rsum, r0;

  dispatch_issue_completion_ctrl i_dut (.clk, .reset_n, .fq_slot, .fq_take,
    .disp_base, .fin, .br_valid, .br_idx, .br_mispredict, .unit_start,
    .unit_op, .retire_cnt, .wb, .prog_int, .prog_int_idx, .refetch,
    .store_commit, .store_commit_idx);
  dic_far_model i_far (.clk, .reset_n, .prog, .len, .restart, .slow,
    .exc_unit, .fq_take, .unit_start, .unit_op, .fq_slot, .fin);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Running count of retirements since reset; scenarios use the difference from r0
  always @(posedge clk)
    rsum <= (reset_n !== 1'b1) ? 0 : rsum + 32'(retire_cnt);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait: 0 retire, 1 interrupt, 2 refetch, 3 store commit,
  // 4 start of the simple integer unit
  task automatic wt(input int w);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (w == 0 && retire_cnt !== 2'h0) return;
      if (w == 1 && prog_int === 1'b1) return;
      if (w == 2 && refetch === 1'b1) return;
      if (w == 3 && store_commit === 1'b1) return;
      if (w == 4 && unit_start[3] === 1'b1) return;
    end
    errors++;
    summarize();
  endtask

  function automatic instr_s mk(unit_e u, ser_e s, logic bp, int f);
    instr_s r;
    r = '0;
    r.valid = 1'b1;
    r.unit = u;
    r.ser = s;
    r.branch_pred = bp;
    if (f >= 0) r.dst[f] = 2'h1;
    return r;
  endfunction

  // Drain the last scenario, then present n program entries
  task automatic go(input int n);
    repeat (20) @(posedge clk);
    restart <= 1'b1;
    len <= 5'(n);
    @(posedge clk);
    restart <= 1'b0;
    #1;
    r0 = rsum;
    t0 = fq_take;
  endtask

  task automatic s_wide; // indices 0..3, slow units
    slow <= 1'b1;
    prog[0] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    prog[1] = mk(U_FLOAT, SER_NONE, 1'b0, 1);
    prog[2] = mk(U_COMPLEX_INT, SER_NONE, 1'b0, 0);
    prog[3] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    go(4);
    chk(8'(t0), 8'h03);
    @(posedge clk);
    #1;
    chk(8'(disp_base), 8'h03);
    repeat (30) @(posedge clk);
    chk(8'(rsum - r0), 8'h04);
    slow <= 1'b0;
  endtask

  task automatic s_wb; // indices 4..6, four general renames
    prog[0] = mk(U_LOAD_STORE, SER_NONE, 1'b0, 0);
    prog[0].dst[0] = 2'h2;
    prog[1] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    prog[2] = mk(U_COMPLEX_INT, SER_NONE, 1'b0, 0);
    go(3);
    wt(0);
    chk(8'(retire_cnt), 8'h02);
    chk(8'(wb[0].cnt), 8'h03);
    chk(8'(wb[0].tag), 8'h03);
  endtask

  task automatic s_ser; // indices 7..9
    prog[0] = mk(U_SIMPLE_INT, SER_EXEC, 1'b0, 0);
    prog[1] = mk(U_FLOAT, SER_NONE, 1'b0, 1);
    prog[2] = mk(U_COMPLEX_INT, SER_REFETCH, 1'b0, 0);
    go(3);
    chk(8'(t0), 8'h01);
    wt(2);
    chk(8'(rsum - r0) + 8'(retire_cnt), 8'h03);
  endtask

  task automatic s_store; // indices 10..11
    prog[0] = mk(U_LOAD_STORE, SER_STORE, 1'b0, 0);
    prog[1] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    go(2);
    chk(8'(t0), 8'h01);
    wt(3);
    chk(8'(store_commit_idx), 8'h0A);
  endtask

  task automatic s_br; // branch 12, younger 13..14 flushed
    prog[0] = mk(U_NONE, SER_NONE, 1'b1, -1);
    prog[1] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    prog[2] = mk(U_FLOAT, SER_NONE, 1'b0, 1);
    go(3);
    chk(8'(t0), 8'h03);
    repeat (8) @(posedge clk);
    chk(8'(rsum - r0), 8'h00);
    br_valid <= 1'b1;
    br_idx <= 4'hC;
    br_mispredict <= 1'b1;
    @(posedge clk);
    br_valid <= 1'b0;
    br_mispredict <= 1'b0;
    repeat (8) @(posedge clk);
    chk(8'(rsum - r0), 8'h01);
    chk(8'(disp_base), 8'h0D);
  endtask

  task automatic s_exc; // 13 retires, 14 faults
    exc_unit <= 5'h08;
    prog[0] = mk(U_FLOAT, SER_NONE, 1'b0, 1);
    prog[1] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    go(2);
    wt(1);
    chk(8'(prog_int_idx), 8'h0E);
    chk(8'(rsum - r0), 8'h01);
    exc_unit <= 5'h00;
  endtask

  task automatic s_dep; // float 14 feeds simple int 15 through rename 3
    prog[0] = mk(U_FLOAT, SER_NONE, 1'b0, 1);
    prog[1] = mk(U_SIMPLE_INT, SER_NONE, 1'b0, 0);
    prog[1].src[0] = '{need: 1'b1, renamed: 1'b1, file: 3'h1, tag: 4'h3};
    go(2);
    chk(8'(t0), 8'h02);
    wt(4);
    chk(8'(fin[2].valid), 8'h01);
    chk(8'(unit_op[3].opnd[0].pend), 8'h01);
    chk(8'(unit_op[3].opnd[0].tag), 8'h03);
  endtask

  initial begin
    reset_n = 1'b0;
    restart = 1'b0;
    slow = 1'b0;
    len = 5'h00;
    br_valid = 1'b0;
    br_idx = 4'h0;
    br_mispredict = 1'b0;
    exc_unit = 5'h00;
    errors = 0;
    checks = 0;
    r0 = 0;
    for (int i = 0; i < 16; i++) prog[i] = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    s_wide();
    s_wb();
    s_ser();
    s_store();
    s_br();
    s_exc();
    s_dep();
    summarize();
  end
endmodule // dispatch_issue_completion_ctrl_tb_top

bind dispatch_issue_completion_ctrl
  dispatch_issue_completion_ctrl_assertions i_chk (.clk, .reset_n, .fq_slot,
    .fq_take, .disp_base, .unit_start, .unit_op, .retire_cnt, .wb,
    .prog_int, .prog_int_idx, .refetch, .store_commit);
